/* logic/rees_top.sv */
// Notes on behaviour
// - a selector register picks the single source of the run enable interlock
// - run enable high permits running; low refuses start and coasts a running drive
// - run enable and emergency stop selector writes are rejected while the drive runs; old setting kept
// - plain inputs one to six come from input status bits 0 to 5
// - bidirectional four to six come from bidirectional status bits 3 to 5
// - run enable may take bit 7 of the fieldbus control word
// - each selector also takes a constant or a bit pointer to any status bit
// - a second selector picks the emergency stop; low means stop active
// - emergency stop ramps the drive down over the configured stop time
// - fault reset source rising edge clears fault once its cause is gone
`timescale 1ns/1ps
`include "rees_map.svh"
module rees_top
#(
  parameter int MS_CYCLES = `REES_ESTOP_UNIT_NS / `REES_CLK_PERIOD_NS
)
(
  input wire logic clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [5:0] digitalInputPins,
  input wire logic [5:0] bidirIoPins,
  input wire logic [15:0] fieldbusControlWordSource,
  input wire logic faultCause,
  output logic modulatorOn,
  output logic coastStop,
  output logic emergencyRampActive,
  output logic faultActive
);
  import rees_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers

  logic [5:0] diMeta_ff;
  logic [5:0] diSync_ff;
  logic [5:0] dioMeta_ff;
  logic [5:0] dioSync_ff;

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      diMeta_ff <= 6'h00;
      diSync_ff <= 6'h00;
      dioMeta_ff <= 6'h00;
      dioSync_ff <= 6'h00;
    end
    else
    begin
      diMeta_ff <= digitalInputPins;
      diSync_ff <= diMeta_ff;
      dioMeta_ff <= bidirIoPins;
      dioSync_ff <= dioMeta_ff;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // registers and bus decode

  rees_state_t state_ff;
  rees_state_t nxt_state;
  logic [9:0] selReg_ff [0:2];
  logic [15:0] estopTime_ff;
  logic refused_ff;
  logic lockRej_ff;
  logic fault_ff;
  logic coast_ff;
  logic [31:0] prdata_ff;
  logic selBits [0:2];
  logic rampBusy;
  logic rampDone;
  logic [15:0] rampRemain;
  logic [15:0] driveStat;
  logic wrAcc;
  logic rdSetup;
  logic selHit;
  logic [1:0] selIdx;
  logic selBadCode;
  logic selLocked;
  logic unmapped;
  logic startPulse;
  logic stopPulse;
  logic startRefused;
  logic selRejected;
  logic runEnable;
  logic estopActive;
  logic frstPrev_ff;
  logic frstRise;

  assign wrAcc = psel && penable && pwrite;
  assign rdSetup = psel && !penable && !pwrite;

  always_comb
  begin
    selHit = 1'b1;
    selIdx = 2'h0;
    unmapped = 1'b0;
    if (paddr == `REES_ADDR_RUNEN_SEL)
      selIdx = 2'h0;
    else if (paddr == `REES_ADDR_ESTOP_SEL)
      selIdx = 2'h1;
    else if (paddr == `REES_ADDR_FRST_SEL)
      selIdx = 2'h2;
    else
    begin
      selHit = 1'b0;
      if (paddr != `REES_ADDR_CTRL && paddr != `REES_ADDR_ESTOP_TIME &&
          paddr != `REES_ADDR_STATUS && paddr != `REES_ADDR_FLAGS)
        unmapped = 1'b1;
    end
  end

  // fieldbus source is offered for run enable only
  assign selBadCode = (pwdata[`REES_SEL_CODE_MSB:`REES_SEL_CODE_LSB] > 4'hC) ||
    (selIdx != 2'h0 && pwdata[`REES_SEL_CODE_MSB:`REES_SEL_CODE_LSB] == 4'h9);
  assign selLocked = (state_ff != ST_IDLE) && (selIdx != 2'h2);
  assign selRejected = wrAcc && selHit && (selLocked || selBadCode);

  assign pready = 1'b1;
  assign pslverr = psel && penable && (unmapped || selRejected);
  assign prdata = prdata_ff;

  assign startPulse = wrAcc && paddr == `REES_ADDR_CTRL && pwdata[`REES_CTRL_START];
  assign stopPulse = wrAcc && paddr == `REES_ADDR_CTRL && pwdata[`REES_CTRL_STOP];

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      selReg_ff[0] <= `REES_RUNEN_SEL_RST;
      selReg_ff[1] <= `REES_ESTOP_SEL_RST;
      selReg_ff[2] <= `REES_FRST_SEL_RST;
    end
    else if (wrAcc && selHit && !selRejected)
      selReg_ff[selIdx] <= pwdata[9:0];
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      estopTime_ff <= `REES_ESTOP_TIME_RST;
    else if (wrAcc && paddr == `REES_ADDR_ESTOP_TIME)
      estopTime_ff <= pwdata[15:0];
  end

  // sticky flags: a new event in the clearing cycle wins
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      refused_ff <= 1'b0;
      lockRej_ff <= 1'b0;
    end
    else
    begin
      if (startRefused)
        refused_ff <= 1'b1;
      else if (wrAcc && paddr == `REES_ADDR_FLAGS && pwdata[`REES_FLAG_REFUSED])
        refused_ff <= 1'b0;
      if (selRejected)
        lockRej_ff <= 1'b1;
      else if (wrAcc && paddr == `REES_ADDR_FLAGS && pwdata[`REES_FLAG_LOCKED])
        lockRej_ff <= 1'b0;
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      prdata_ff <= 32'h0000_0000;
    else if (rdSetup)
    begin
      if (paddr == `REES_ADDR_RUNEN_SEL)
        prdata_ff <= {22'h000000, selReg_ff[0]};
      else if (paddr == `REES_ADDR_ESTOP_SEL)
        prdata_ff <= {22'h000000, selReg_ff[1]};
      else if (paddr == `REES_ADDR_FRST_SEL)
        prdata_ff <= {22'h000000, selReg_ff[2]};
      else if (paddr == `REES_ADDR_ESTOP_TIME)
        prdata_ff <= {16'h0000, estopTime_ff};
      else if (paddr == `REES_ADDR_STATUS)
        prdata_ff <= {rampRemain, 9'h000, coast_ff, rampBusy, fault_ff,
          estopActive, runEnable, state_ff};
      else if (paddr == `REES_ADDR_FLAGS)
        prdata_ff <= {30'h0000_0000, lockRej_ff, refused_ff};
      else
        prdata_ff <= 32'h0000_0000;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // source selectors: run enable, emergency stop, fault reset

  assign driveStat = {12'h000, fault_ff, coast_ff, state_ff};

  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++)
    begin : g_sel
      rees_src_mux u_mux (
        .clk(clk),
        .rst(rst),
        .code(rees_src_t'(selReg_ff[gi][`REES_SEL_CODE_MSB:`REES_SEL_CODE_LSB])),
        .ptrWord(rees_ptr_t'(selReg_ff[gi][`REES_SEL_WORD_MSB:`REES_SEL_WORD_LSB])),
        .ptrBit(selReg_ff[gi][`REES_SEL_BIT_MSB:`REES_SEL_BIT_LSB]),
        .di(diSync_ff),
        .dio(dioSync_ff),
        .cw(fieldbusControlWordSource),
        .stat(driveStat),
        .selBit_ff(selBits[gi])
      );
    end
  endgenerate

  assign runEnable = selBits[0];
  assign estopActive = !selBits[1];

  ////////////////////////////////////////////////////////////////////////////
  // fault reset on a rising edge of its source

  assign frstRise = selBits[2] && !frstPrev_ff;

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      frstPrev_ff <= 1'b0;
      fault_ff <= 1'b0;
    end
    else
    begin
      frstPrev_ff <= selBits[2];
      if (faultCause)
        fault_ff <= 1'b1;
      else if (frstRise)
        fault_ff <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // drive run control

  rees_decel_ramp #(
    .MS_CYCLES(MS_CYCLES)
  ) u_ramp (
    .clk(clk),
    .rst(rst),
    .start(state_ff == ST_RUN && nxt_state == ST_ESTOP),
    .abort(state_ff == ST_ESTOP && nxt_state != ST_ESTOP && !rampDone),
    .timeMs(estopTime_ff),
    .busy_ff(rampBusy),
    .done_ff(rampDone),
    .remain_ff(rampRemain)
  );

  // a lost run enable always coasts, even out of an emergency ramp
  assign startRefused = (state_ff == ST_IDLE) && startPulse &&
    (!runEnable || estopActive || fault_ff);

  always_comb
  begin
    nxt_state = state_ff;
    case (state_ff)
      ST_IDLE:
        if (startPulse && !startRefused)
          nxt_state = ST_RUN;
      ST_RUN:
        if (!runEnable)
          nxt_state = ST_IDLE;
        else if (estopActive)
          nxt_state = ST_ESTOP;
        else if (stopPulse || fault_ff)
          nxt_state = ST_IDLE;
      ST_ESTOP:
        if (!runEnable || rampDone)
          nxt_state = ST_IDLE;
      default:
        nxt_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      state_ff <= ST_IDLE;
    else
      state_ff <= nxt_state;
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      coast_ff <= 1'b0;
    else if (state_ff != ST_IDLE && !runEnable)
      coast_ff <= 1'b1;
    else if (nxt_state == ST_RUN)
      coast_ff <= 1'b0;
  end

  assign modulatorOn = (state_ff != ST_IDLE);
  assign coastStop = coast_ff;
  assign emergencyRampActive = (state_ff == ST_ESTOP);
  assign faultActive = fault_ff;

  ////////////////////////////////////////////////////////////////////////////

  AST_START_REFUSED: assert property (@(posedge clk) disable iff (rst)
    (state_ff == ST_IDLE && startPulse && !runEnable)
    |=> (state_ff == ST_IDLE && refused_ff))
    else $error("start taken without run enable");

  AST_COAST_ON_LOSS: assert property (@(posedge clk) disable iff (rst)
    (state_ff == ST_RUN && !runEnable) |=> (state_ff == ST_IDLE && coast_ff))
    else $error("running drive did not coast on lost run enable");

  AST_SEL_LOCKED: assert property (@(posedge clk) disable iff (rst)
    (state_ff != ST_IDLE) |=> ($stable(selReg_ff[0]) && $stable(selReg_ff[1])))
    else $error("source selection changed while running");

  AST_ESTOP_STOPS: assert property (@(posedge clk) disable iff (rst)
    (state_ff == ST_RUN && estopActive) |=> (state_ff != ST_RUN))
    else $error("drive kept running with emergency stop active");

  AST_ESTOP_RAMP: assert property (@(posedge clk) disable iff (rst)
    (state_ff == ST_RUN && runEnable && estopActive)
    |=> (state_ff == ST_ESTOP && rampBusy && rampRemain == $past(estopTime_ff)))
    else $error("emergency ramp not started with the stop time");

  AST_FAULT_RESET: assert property (@(posedge clk) disable iff (rst)
    (fault_ff && frstRise && !faultCause) |=> !fault_ff)
    else $error("fault not cleared on reset edge");

  AST_RUNEN_LATENCY: assert property (@(posedge clk) disable iff (rst)
    (selReg_ff[0][3:0] == 4'hB) ##1 (selReg_ff[0][3:0] == 4'hB) |-> runEnable)
    else $error("run enable not updated one cycle after sampling");

endmodule

/* logic/rees_map.svh */
`ifndef REES_MAP_SVH
`define REES_MAP_SVH

// apb byte offsets
`define REES_ADDR_CTRL 8'h00
`define REES_ADDR_RUNEN_SEL 8'h04
`define REES_ADDR_ESTOP_SEL 8'h08
`define REES_ADDR_FRST_SEL 8'h0C
`define REES_ADDR_ESTOP_TIME 8'h10
`define REES_ADDR_STATUS 8'h14
`define REES_ADDR_FLAGS 8'h18

// control register bits (write-only pulses)
`define REES_CTRL_START 0
`define REES_CTRL_STOP 1

// selector register layout
`define REES_SEL_CODE_LSB 0
`define REES_SEL_CODE_MSB 3
`define REES_SEL_WORD_LSB 4
`define REES_SEL_WORD_MSB 5
`define REES_SEL_BIT_LSB 6
`define REES_SEL_BIT_MSB 9

// selector reset values: run enable high and stop inactive, fault reset idle
`define REES_RUNEN_SEL_RST 10'h00B
`define REES_ESTOP_SEL_RST 10'h00B
`define REES_FRST_SEL_RST 10'h00A
`define REES_ESTOP_TIME_RST 16'h03E8

// status register fields
`define REES_STAT_STATE_LSB 0
`define REES_STAT_STATE_MSB 1
`define REES_STAT_RUNEN 2
`define REES_STAT_ESTOP 3
`define REES_STAT_FAULT 4
`define REES_STAT_RAMP 5
`define REES_STAT_COAST 6
`define REES_STAT_REMAIN_LSB 16

// sticky flags, write one to clear
`define REES_FLAG_REFUSED 0
`define REES_FLAG_LOCKED 1

// fieldbus control word bit that carries run enable
`define REES_CW_RUNEN_BIT 7

// emergency stop time unit and clock period
`define REES_ESTOP_UNIT_NS 1000000
`define REES_CLK_PERIOD_NS 25

`endif

/* logic/rees_pkg.sv */
package rees_pkg;

  typedef enum logic [3:0] {
    SRC_IN_ONE = 4'h0,
    SRC_IN_TWO = 4'h1,
    SRC_IN_THREE = 4'h2,
    SRC_IN_FOUR = 4'h3,
    SRC_IN_FIVE = 4'h4,
    SRC_IN_SIX = 4'h5,
    SRC_BIDIR_FOUR = 4'h6,
    SRC_BIDIR_FIVE = 4'h7,
    SRC_BIDIR_SIX = 4'h8,
    SRC_FIELDBUS = 4'h9,
    SRC_CONST_LOW = 4'hA,
    SRC_CONST_HIGH = 4'hB,
    SRC_POINTER = 4'hC
  } rees_src_t;

  typedef enum logic [1:0] {
    PTR_INPUTS = 2'b00,
    PTR_BIDIR = 2'b01,
    PTR_FIELDBUS = 2'b10,
    PTR_DRIVE = 2'b11
  } rees_ptr_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_RUN = 2'b01,
    ST_ESTOP = 2'b10
  } rees_state_t;

endpackage

/* logic/rees_src_mux.sv */
`timescale 1ns/1ps
`include "rees_map.svh"
module rees_src_mux
(
  input wire logic clk,
  input wire logic rst,
  input wire rees_pkg::rees_src_t code,
  input wire rees_pkg::rees_ptr_t ptrWord,
  input wire logic [3:0] ptrBit,
  input wire logic [5:0] di,
  input wire logic [5:0] dio,
  input wire logic [15:0] cw,
  input wire logic [15:0] stat,
  output logic selBit_ff
);
  import rees_pkg::*;

  logic [15:0] ptrData;
  logic nxt_selBit;
  logic [3:0] dioIdx;

  assign dioIdx = code - 4'h3;

  always_comb
  begin
    case (ptrWord)
      PTR_INPUTS: ptrData = {10'h000, di};
      PTR_BIDIR: ptrData = {10'h000, dio};
      PTR_FIELDBUS: ptrData = cw;
      default: ptrData = stat;
    endcase
  end

  always_comb
  begin
    case (code)
      SRC_IN_ONE, SRC_IN_TWO, SRC_IN_THREE,
      SRC_IN_FOUR, SRC_IN_FIVE, SRC_IN_SIX: nxt_selBit = di[code[2:0]];
      SRC_BIDIR_FOUR, SRC_BIDIR_FIVE, SRC_BIDIR_SIX: nxt_selBit = dio[dioIdx[2:0]];
      SRC_FIELDBUS: nxt_selBit = cw[`REES_CW_RUNEN_BIT];
      SRC_CONST_LOW: nxt_selBit = 1'b0;
      SRC_CONST_HIGH: nxt_selBit = 1'b1;
      SRC_POINTER: nxt_selBit = ptrData[ptrBit];
      default: nxt_selBit = 1'b0;
    endcase
  end

  // one sample per control cycle, seen by the drive logic on the next
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      selBit_ff <= 1'b0;
    else
      selBit_ff <= nxt_selBit;
  end

  ////////////////////////////////////////////////////////////////////////////

  AST_PLAIN_INPUT: assert property (@(posedge clk) disable iff (rst)
    (code <= SRC_IN_SIX) |=> (selBit_ff == $past(di[code[2:0]])))
    else $error("plain input not routed to selector output");

  AST_BIDIR_INPUT: assert property (@(posedge clk) disable iff (rst)
    (code >= SRC_BIDIR_FOUR && code <= SRC_BIDIR_SIX)
    |=> (selBit_ff == $past(dio[dioIdx[2:0]])))
    else $error("bidirectional input bit not routed");

  AST_FIELDBUS_BIT: assert property (@(posedge clk) disable iff (rst)
    (code == SRC_FIELDBUS) |=> (selBit_ff == $past(cw[`REES_CW_RUNEN_BIT])))
    else $error("fieldbus control word bit 7 not routed");

  AST_POINTER_BIT: assert property (@(posedge clk) disable iff (rst)
    (code == SRC_POINTER && ptrWord == PTR_FIELDBUS)
    |=> (selBit_ff == $past(cw[ptrBit])))
    else $error("bit pointer picked the wrong status bit");

endmodule

/* logic/rees_decel_ramp.sv */
`timescale 1ns/1ps
module rees_decel_ramp
#(
  parameter int MS_CYCLES = 40000
)
(
  input wire logic clk,
  input wire logic rst,
  input wire logic start,
  input wire logic abort,
  input wire logic [15:0] timeMs,
  output logic busy_ff,
  output logic done_ff,
  output logic [15:0] remain_ff
);

  logic [31:0] tickCnt_ff;
  logic tick;

  assign tick = (tickCnt_ff == 32'(MS_CYCLES - 1));

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      tickCnt_ff <= 32'h0000_0000;
    else if (start || !busy_ff || tick)
      tickCnt_ff <= 32'h0000_0000;
    else
      tickCnt_ff <= tickCnt_ff + 32'h0000_0001;
  end

  // ramp length follows the stop time setting, one step per millisecond
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      busy_ff <= 1'b0;
      done_ff <= 1'b0;
      remain_ff <= 16'h0000;
    end
    else
    begin
      done_ff <= 1'b0;
      if (abort)
      begin
        busy_ff <= 1'b0;
        remain_ff <= 16'h0000;
      end
      else if (start)
      begin
        busy_ff <= 1'b1;
        remain_ff <= timeMs;
      end
      else if (busy_ff && remain_ff == 16'h0000)
      begin
        busy_ff <= 1'b0;
        done_ff <= 1'b1;
      end
      else if (busy_ff && tick)
        remain_ff <= remain_ff - 16'h0001;
    end
  end

  AST_RAMP_LOAD: assert property (@(posedge clk) disable iff (rst)
    (start && !abort) |=> (busy_ff && remain_ff == $past(timeMs)))
    else $error("stop ramp did not load the stop time");

endmodule

/* verification/rees_io_model.sv */
`timescale 1ns/1ps
module rees_io_model
(
  input wire logic clk,
  input wire logic slow,
  input wire logic [5:0] diSet,
  input wire logic [5:0] dioSet,
  input wire logic [15:0] cwSet,
  output logic [5:0] diPins,
  output logic [5:0] dioPins,
  output logic [15:0] cwWord
);
  logic [27:0] stage_ff;
  // slow terminals settle one cycle later, like a contact that bounces
  always_ff @(posedge clk)
  begin
    stage_ff <= {diSet, dioSet, cwSet};
  end
  always_ff @(posedge clk)
  begin
    {diPins, dioPins, cwWord} <= slow ? stage_ff : {diSet, dioSet, cwSet};
  end
endmodule

/* verification/run_enable_estop_source_select_tb.sv */
`timescale 1ns/1ps
`include "rees_map.svh"
module run_enable_estop_source_select_tb;
  import rees_pkg::*;
  logic clk, rst, psel, penable, pwrite, pready, pslverr, slow, faultCause, err;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [5:0] diSet, dioSet, diPins, dioPins;
  logic [15:0] cwSet, cwWord;
  logic modulatorOn, coastStop, emergencyRampActive, faultActive;
  logic [9:0] runSel, estSel;
  int miscompares = 0;
  int total_checks = 0;
  int n;
  //////////////////////////////////////////////////////////////////////////////
  rees_top #(.MS_CYCLES(4)) DUT (.clk(clk), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .digitalInputPins(diPins), .bidirIoPins(dioPins),
    .fieldbusControlWordSource(cwWord), .faultCause(faultCause), .modulatorOn(modulatorOn),
    .coastStop(coastStop), .emergencyRampActive(emergencyRampActive),
    .faultActive(faultActive));
  rees_io_model model (.clk(clk), .slow(slow), .diSet(diSet), .dioSet(dioSet),
    .cwSet(cwSet), .diPins(diPins), .dioPins(dioPins), .cwWord(cwWord));
  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  //////////////////////////////////////////////////////////////////////////////
  task automatic test_done;
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chkReg(input logic [31:0] got, input logic [31:0] exp, input string what);
    total_checks++;
    if (got !== exp)
    begin
      miscompares++;
      $display("Error %0t %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  task automatic chkBit(input logic got, input logic exp, input string what);
    total_checks++;
    if (got !== exp)
    begin
      miscompares++;
      $display("Error %0t %s got %b expected %b", $time, what, got, exp);
    end
  endtask
  task automatic cyc(input int k);
    repeat (k) @(posedge clk);
  endtask
  // one idle cycle after each transfer so psel is never driven twice in a step
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int k;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    k = 0;
    do
    begin
      @(posedge clk);
      k++;
    end
    while (pready !== 1'b1 && k < 16);
    rd = prdata;
    err = pslverr;
    if (k >= 16)
    begin
      miscompares++;
      $display("Error %0t bus answer missing", $time);
      test_done();
    end
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
  //////////////////////////////////////////////////////////////////////////////
  function automatic logic expBit(input logic [9:0] s, input logic [5:0] d,
                                  input logic [5:0] io, input logic [15:0] w);
    logic [3:0] c;
    c = s[3:0];
    if (c <= 4'h5) return d[c];
    if (c <= 4'h8) return io[c - 4'h3];
    if (c == 4'h9) return w[`REES_CW_RUNEN_BIT];
    if (c == 4'hA) return 1'b0;
    if (c == 4'hB) return 1'b1;
    if (s[5:4] == 2'h0) return d[s[9:6]];
    if (s[5:4] == 2'h1) return io[s[9:6]];
    if (s[5:4] == 2'h2) return w[s[9:6]];
    // drive status word is all zero while idle with no fault and no coast
    return 1'b0;
  endfunction
  function automatic logic [9:0] randSel(input int i);
    logic [3:0] c;
    logic [1:0] wd;
    logic [3:0] b;
    c = (i < 13) ? i[3:0] : 4'($urandom % 13);
    wd = 2'($urandom);
    b = (wd == 2'h2) ? 4'($urandom % 16) : 4'($urandom % 6);
    return {b, wd, c};
  endfunction
  //////////////////////////////////////////////////////////////////////////////
  initial
  begin
    cyc(100000);
    miscompares++;
    $display("Error %0t run did not finish", $time);
    test_done();
  end
  initial
  begin
    rst = 1'b1;
    {psel, penable, pwrite, slow, faultCause} = 5'h00;
    paddr = 8'h00;
    pwdata = 32'h0;
    {diSet, dioSet, cwSet} = 28'h0;
    estSel = `REES_ESTOP_SEL_RST;
    void'($urandom(32'hCB26C537));
    cyc(5);
    rst <= 1'b0;
    @(posedge clk);
    apb(0, `REES_ADDR_RUNEN_SEL, 32'h0);
    chkReg(rd, 32'h0000000B, "run enable select reset");
    apb(0, `REES_ADDR_ESTOP_SEL, 32'h0);
    chkReg(rd, 32'h0000000B, "stop select reset");
    apb(0, `REES_ADDR_ESTOP_TIME, 32'h0);
    chkReg(rd, 32'h000003E8, "stop time reset");
    apb(0, 8'h1C, 32'h0);
    chkBit(err, 1'b1, "unmapped error");
    chkReg(rd, 32'h0, "unmapped read");
    $display("test reset done");
    for (int i = 0; i < 33; i++)
    begin
      runSel = randSel(i);
      apb(1, `REES_ADDR_RUNEN_SEL, {22'h0, runSel});
      chkBit(err, 1'b0, "run enable select write");
      apb(1, `REES_ADDR_ESTOP_SEL, {22'h0, runSel});
      chkBit(err, runSel[3:0] == 4'h9, "stop select write");
      if (!err)
        estSel = runSel;
      diSet <= 6'($urandom);
      dioSet <= 6'($urandom);
      cwSet <= 16'($urandom);
      slow <= 1'($urandom);
      cyc(6);
      apb(0, `REES_ADDR_STATUS, 32'h0);
      chkBit(rd[2], expBit(runSel, diSet, dioSet, cwSet), "run enable");
      chkBit(rd[3], !expBit(estSel, diSet, dioSet, cwSet), "stop active");
    end
    apb(1, `REES_ADDR_RUNEN_SEL, 32'h0000000D);
    chkBit(err, 1'b1, "bad code refused");
    apb(1, `REES_ADDR_FLAGS, 32'h3);
    $display("test routing done");
    apb(1, `REES_ADDR_RUNEN_SEL, 32'h0);
    apb(1, `REES_ADDR_ESTOP_SEL, 32'h0000000B);
    diSet <= 6'h01;
    slow <= 1'b0;
    cyc(6);
    apb(1, `REES_ADDR_CTRL, 32'h1);
    cyc(2);
    chkBit(modulatorOn, 1'b1, "start");
    apb(1, `REES_ADDR_RUNEN_SEL, 32'h0000000B);
    chkBit(err, 1'b1, "locked run enable");
    apb(1, `REES_ADDR_ESTOP_SEL, 32'h00000001);
    chkBit(err, 1'b1, "locked stop");
    apb(0, `REES_ADDR_RUNEN_SEL, 32'h0);
    chkReg(rd, 32'h0, "setting kept");
    apb(0, `REES_ADDR_FLAGS, 32'h0);
    chkReg(rd & 32'h2, 32'h2, "locked flag");
    diSet <= 6'h00;
    cyc(6);
    chkBit(modulatorOn, 1'b0, "coast release");
    chkBit(coastStop, 1'b1, "coast flag");
    apb(1, `REES_ADDR_FLAGS, 32'h3);
    apb(1, `REES_ADDR_CTRL, 32'h1);
    cyc(2);
    chkBit(modulatorOn, 1'b0, "start without enable");
    apb(0, `REES_ADDR_FLAGS, 32'h0);
    chkReg(rd, 32'h1, "refused flag");
    $display("test run enable done");
    apb(1, `REES_ADDR_RUNEN_SEL, 32'h0000000B);
    apb(1, `REES_ADDR_ESTOP_SEL, 32'h00000001);
    apb(1, `REES_ADDR_ESTOP_TIME, 32'h2);
    diSet <= 6'h02;
    cyc(6);
    apb(1, `REES_ADDR_CTRL, 32'h1);
    cyc(2);
    chkBit(modulatorOn, 1'b1, "start with stop clear");
    chkBit(coastStop, 1'b0, "coast cleared");
    diSet <= 6'h00;
    cyc(6);
    chkBit(emergencyRampActive, 1'b1, "ramp stop active");
    n = 0;
    while (modulatorOn === 1'b1 && n < 40)
    begin
      @(posedge clk);
      n++;
    end
    // two ms at four cycles each plus hand-over, measured from six cycles in
    chkBit(n >= 8 && n <= 18, 1'b1, "ramp length");
    apb(1, `REES_ADDR_CTRL, 32'h1);
    cyc(2);
    chkBit(modulatorOn, 1'b0, "start under stop");
    $display("test ramp stop done");
    faultCause <= 1'b1;
    cyc(1);
    faultCause <= 1'b0;
    cyc(2);
    chkBit(faultActive, 1'b1, "fault latched");
    apb(1, `REES_ADDR_FRST_SEL, 32'h0000000B);
    cyc(3);
    chkBit(faultActive, 1'b0, "fault reset edge");
    $display("test fault reset done");
    diSet <= 6'h02;
    cyc(6);
    apb(1, `REES_ADDR_CTRL, 32'h1);
    cyc(2);
    chkBit(modulatorOn, 1'b1, "restart after fault reset");
    apb(1, `REES_ADDR_CTRL, 32'h2);
    cyc(2);
    chkBit(modulatorOn, 1'b0, "stop command");
    chkBit(coastStop, 1'b0, "stop is not a coast");
    apb(1, `REES_ADDR_ESTOP_SEL, 32'h0000000B);
    chkBit(err, 1'b0, "selector free after stop");
    $display("test stop command done");
    test_done();
  end
endmodule
